// ==== sfd_pkg.sv ====
package sfd_pkg;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int F_WRITE = 15;
	localparam int F_BANK = 14;
	localparam int F_ADDR_HI = 13;
	localparam int F_ADDR_LO = 8;
	localparam int F_DIAG_REQ = 0;
	localparam logic [2:0] BIT_IN_BYTE_ZERO = 3'h0;
	localparam logic [2:0] BIT_IN_BYTE_LAST = 3'h7;
	localparam logic [2:0] BIT_IN_BYTE_FIRST = 3'h1;
	localparam logic [1:0] MIN_BYTES = 2'h2;
	localparam logic [4:0] TX_DONE_IDX = 5'h10;
	localparam logic [3:0] TX_TOP_BIT = 4'hf;

	// ----------------------------------------------------------------
	// Bank 0 register map
	// ----------------------------------------------------------------
	localparam int NUM_REGS = 9;
	localparam logic [8:0][5:0] REG_ADDR = {6'h3e, 6'h0f, 6'h0c, 6'h0a, 6'h09, 6'h06, 6'h05, 6'h03, 6'h00};
	localparam logic [8:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf0};
	localparam logic [3:0] IDX_CAL = 4'h1;
	localparam logic [3:0] IDX_DEV = 4'h3;
	localparam logic [3:0] IDX_MFS = 4'h4;
	localparam logic [3:0] IDX_MON = 4'h6;
	localparam int B_START = 5;
	localparam int B_DONE = 4;
	localparam int B_CLEAR_LATCHES = 2;
	localparam int B_SOFT_RESET = 1;
	localparam logic [7:0] DONE_MASK = 8'h10;
	localparam logic [7:0] DEV_CMD_MASK = 8'h06;

	// ----------------------------------------------------------------
	// Diagnosis word
	// ----------------------------------------------------------------
	localparam logic [1:0] ST_RESERVED = 2'h0;
	localparam logic [1:0] ST_IDLE = 2'h3;
	localparam logic [15:0] RESP_RESET = 16'h3c00;

	typedef struct packed {
		logic [1:0] op_state;
		logic thermal_warning;
		logic load_current;
		logic driver_uv;
		logic output_ov;
		logic regulator_uv;
		logic shorted_load;
		logic thermal_shutdown;
		logic cal_ok;
		logic mon_ok;
		logic mfs_ok;
		logic enable_uv;
	} sfd_sense_type;

	typedef struct packed {
		logic always_zero_hi;
		logic soft_reset_or_driver_uv_flag;
		logic supply_undervolt_reset_flag;
		logic [1:0] op_state;
		logic transfer_error_flag;
		logic monitor_done_flag;
		logic multi_float_done_flag;
		logic calibration_done_flag;
		logic always_zero_mid;
		logic output_overvoltage_flag;
		logic regulator_undervolt_flag;
		logic load_current_present_flag;
		logic shorted_load_flag;
		logic thermal_shutdown_flag;
		logic thermal_warning_flag;
	} sfd_diag_type;

endpackage

// ==== sfd_spi_diag.sv ====
`timescale 1ns/1ns

module sfd_spi_diag (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Serial link
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so_out,
	output logic spi_so_oe_n,
	// Analog status, asynchronous
	input wire sfd_pkg::sfd_sense_type sense_in,
	// Configuration register contents
	output logic [8:0][7:0] cfg_regs_q
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic fresh_q;
	logic [15:0] rx_sr_q;
	logic [2:0] bit_q;
	logic [1:0] bytes_q;
	logic [4:0] tx_idx_q;
	logic cs_meta_q;
	logic cs_sync_q;
	logic cs_last_q;
	sfd_pkg::sfd_sense_type sense_meta_q;
	sfd_pkg::sfd_sense_type sense_sync_q;
	sfd_pkg::sfd_sense_type sense_last_q;
	logic [15:0] resp_q;
	logic [15:0] resp_d;
	logic [1:0] state_q;
	logic soft_reset_q;
	logic uvlo_q;
	logic output_overvoltage_flag_q;
	logic ivcc_q;
	logic short_q;
	logic tsd_q;
	logic cal_done_q;
	logic mon_done_q;
	logic mfs_done_q;
	logic fresh_pend_q;
	logic [8:0][7:0] regs_d;
	sfd_pkg::sfd_diag_type diag;

	function automatic logic [4:0] lookup_addr(input logic [5:0] addr);
		logic [4:0] res;
		res = 5'h00;
		for (int i = 0; i < sfd_pkg::NUM_REGS; i++) begin
			if (sfd_pkg::REG_ADDR[i] == addr) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Link domain: receive on falling edge
	// ----------------------------------------------------------------
	// The chip select itself is the crossing handshake: the receive registers
	// stop with the clock and are only read once the frame has ended, so they
	// are not cleared by chip select but on the first falling edge of the next frame.
	always_ff @(negedge spi_clk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	always_ff @(negedge spi_clk) begin
		rx_sr_q <= {(fresh_q ? 15'h0000 : rx_sr_q[14:0]), spi_si};
		bit_q <= fresh_q ? sfd_pkg::BIT_IN_BYTE_FIRST : bit_q + 3'h1;
		if (fresh_q) begin
			bytes_q <= 2'h0;
		end else if (bit_q == sfd_pkg::BIT_IN_BYTE_LAST && bytes_q != sfd_pkg::MIN_BYTES) begin
			bytes_q <= bytes_q + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: transmit on rising edge
	// ----------------------------------------------------------------
	// The answer word is held still by the system side for the whole frame,
	// so it can be read here without further synchronisation.
	always_ff @(posedge spi_clk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			tx_idx_q <= 5'h00;
			spi_so_out <= 1'b0;
		end else begin
			spi_so_out <= tx_idx_q[4] ? 1'b0 : resp_q[sfd_pkg::TX_TOP_BIT - tx_idx_q[3:0]];
			if (tx_idx_q != sfd_pkg::TX_DONE_IDX) begin
				tx_idx_q <= tx_idx_q + 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// System domain: synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
			cs_last_q <= 1'b1;
			spi_so_oe_n <= 1'b1;
			sense_meta_q <= '0;
			sense_sync_q <= '0;
			sense_last_q <= '0;
		end else begin
			cs_meta_q <= spi_cs_n;
			cs_sync_q <= cs_meta_q;
			cs_last_q <= cs_sync_q;
			spi_so_oe_n <= cs_sync_q;
			sense_meta_q <= sense_in;
			sense_sync_q <= sense_meta_q;
			sense_last_q <= sense_sync_q;
		end
	end

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	wire frame_end = cs_sync_q & ~cs_last_q;
	wire frame_ok = (bit_q == sfd_pkg::BIT_IN_BYTE_ZERO) && (bytes_q == sfd_pkg::MIN_BYTES);
	wire cmd_write = rx_sr_q[sfd_pkg::F_WRITE];
	wire cmd_bank = rx_sr_q[sfd_pkg::F_BANK];
	wire [4:0] hit = lookup_addr(rx_sr_q[sfd_pkg::F_ADDR_HI:sfd_pkg::F_ADDR_LO]);
	wire [3:0] idx = hit[3:0];
	wire reg_valid = hit[4] & ~cmd_bank;
	wire diag_req = ~cmd_write & rx_sr_q[sfd_pkg::F_DIAG_REQ];
	wire [7:0] wr_data = rx_sr_q[7:0];
	wire answer_reg = frame_ok & ~fresh_pend_q & reg_valid & ~diag_req;
	wire send_diag = frame_end & ~answer_reg;
	wire write_ok = frame_end & frame_ok & cmd_write & reg_valid;
	wire wr_dev = write_ok && idx == sfd_pkg::IDX_DEV;
	wire clear_latches = wr_dev & wr_data[sfd_pkg::B_CLEAR_LATCHES];
	wire soft_reset = wr_dev & wr_data[sfd_pkg::B_SOFT_RESET];
	wire start_cal = write_ok && idx == sfd_pkg::IDX_CAL && wr_data[sfd_pkg::B_START];
	wire start_mfs = write_ok && idx == sfd_pkg::IDX_MFS && wr_data[sfd_pkg::B_START];
	wire start_mon = write_ok && idx == sfd_pkg::IDX_MON && wr_data[sfd_pkg::B_START];
	wire en_uv_rise = sense_sync_q.enable_uv & ~sense_last_q.enable_uv;
	wire cal_rise = sense_sync_q.cal_ok & ~sense_last_q.cal_ok;
	wire mon_rise = sense_sync_q.mon_ok & ~sense_last_q.mon_ok;
	wire mfs_rise = sense_sync_q.mfs_ok & ~sense_last_q.mfs_ok;

	// ----------------------------------------------------------------
	// Register read value and next register contents
	// ----------------------------------------------------------------
	wire has_done = (idx == sfd_pkg::IDX_CAL) || (idx == sfd_pkg::IDX_MFS) || (idx == sfd_pkg::IDX_MON);
	wire done_sel = (idx == sfd_pkg::IDX_CAL) ? cal_done_q : (idx == sfd_pkg::IDX_MFS) ? mfs_done_q : mon_done_q;
	wire [7:0] done_bits = (has_done && done_sel) ? sfd_pkg::DONE_MASK : 8'h00;
	wire [7:0] rd_data = cfg_regs_q[idx] | done_bits;
	wire [7:0] ro_mask = (has_done ? sfd_pkg::DONE_MASK : 8'h00) | (idx == sfd_pkg::IDX_DEV ? sfd_pkg::DEV_CMD_MASK : 8'h00);

	always_comb begin
		regs_d = cfg_regs_q;
		if (soft_reset || en_uv_rise) begin
			regs_d = sfd_pkg::REG_RESET;
		end else if (write_ok) begin
			regs_d[idx] = wr_data & ~ro_mask;
		end
	end

	// ----------------------------------------------------------------
	// Diagnosis word and answer selection
	// ----------------------------------------------------------------
	assign diag = '{
		always_zero_hi: 1'b0,
		soft_reset_or_driver_uv_flag: soft_reset_q | sense_sync_q.driver_uv,
		supply_undervolt_reset_flag: uvlo_q,
		op_state: state_q,
		transfer_error_flag: ~frame_ok,
		monitor_done_flag: mon_done_q,
		multi_float_done_flag: mfs_done_q,
		calibration_done_flag: cal_done_q,
		always_zero_mid: 1'b0,
		output_overvoltage_flag: output_overvoltage_flag_q,
		regulator_undervolt_flag: ivcc_q,
		load_current_present_flag: sense_sync_q.load_current,
		shorted_load_flag: short_q,
		thermal_shutdown_flag: tsd_q,
		thermal_warning_flag: sense_sync_q.thermal_warning
	};

	// The MSB set and the echoed address tell the master which register came back.
	assign resp_d = answer_reg ? {1'b1, rx_sr_q[14:8], rd_data} : diag;

	// ----------------------------------------------------------------
	// System domain state
	// ----------------------------------------------------------------
	// Every flag takes its set after its clear, so an event in the cycle of
	// the readout stays pending for the next one.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			resp_q <= sfd_pkg::RESP_RESET;
			state_q <= sfd_pkg::ST_IDLE;
			soft_reset_q <= 1'b0;
			uvlo_q <= 1'b1;
			output_overvoltage_flag_q <= 1'b0;
			ivcc_q <= 1'b0;
			short_q <= 1'b0;
			tsd_q <= 1'b0;
			cal_done_q <= 1'b0;
			mon_done_q <= 1'b0;
			mfs_done_q <= 1'b0;
			fresh_pend_q <= 1'b0;
			cfg_regs_q <= sfd_pkg::REG_RESET;
		end else begin
			if (frame_end) begin
				resp_q <= resp_d;
			end
			if (sense_sync_q.op_state != sfd_pkg::ST_RESERVED) begin
				state_q <= sense_sync_q.op_state;
			end
			soft_reset_q <= (soft_reset_q & ~send_diag) | soft_reset;
			uvlo_q <= (uvlo_q & ~send_diag) | en_uv_rise;
			output_overvoltage_flag_q <= (output_overvoltage_flag_q & ~send_diag) | sense_sync_q.output_ov;
			ivcc_q <= (ivcc_q & ~send_diag) | sense_sync_q.regulator_uv;
			short_q <= (short_q & ~send_diag) | sense_sync_q.shorted_load;
			tsd_q <= (tsd_q & ~clear_latches) | sense_sync_q.thermal_shutdown;
			cal_done_q <= (cal_done_q & ~start_cal) | cal_rise;
			mon_done_q <= (mon_done_q & ~start_mon) | mon_rise;
			mfs_done_q <= (mfs_done_q & ~start_mfs) | mfs_rise;
			fresh_pend_q <= (fresh_pend_q & ~frame_end) | en_uv_rise;
			cfg_regs_q <= regs_d;
		end
	end

endmodule

// ==== sfd_chk_sva.sv ====
`timescale 1ns/1ns
module sfd_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	input wire logic spi_so_out,
	input wire logic spi_so_oe_n,
	input wire sfd_pkg::sfd_sense_type sense_in,
	input wire logic [8:0][7:0] cfg_regs_q
);
	// ----------------
	// Link and register checks seen from the system clock
	// ----------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_so_idle; spi_cs_n && $past(spi_cs_n) |-> !spi_so_out; endproperty
	a_so_idle: assert property (p_so_idle) else $error("data out high while deselected");
	property p_so_lead; $fell(spi_cs_n) |-> !spi_so_out [*3]; endproperty
	a_so_lead: assert property (p_so_lead) else $error("data out high before first clock");
	property p_so_stand; $changed(spi_so_out) |-> $rose(spi_clk) || $rose(spi_cs_n); endproperty
	a_so_stand: assert property (p_so_stand) else $error("data out moved off a clock edge");
	property p_oe_on; !spi_cs_n [*3] |=> !spi_so_oe_n; endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not enabled in frame");
	property p_oe_off; spi_cs_n [*3] |=> spi_so_oe_n; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output enabled between frames");
	property p_oe_why; $fell(spi_so_oe_n) |-> !spi_cs_n && !$past(spi_cs_n, 2); endproperty
	a_oe_why: assert property (p_oe_why) else $error("output enabled too early");
	property p_rst; $fell(sys_rst) |-> spi_so_oe_n && cfg_regs_q == sfd_pkg::REG_RESET; endproperty
	a_rst: assert property (p_rst) else $error("wrong state after reset");
	property p_cfg; $changed(cfg_regs_q) |-> spi_cs_n && $past(spi_cs_n) || $past(sense_in.enable_uv, 4); endproperty
	a_cfg: assert property (p_cfg) else $error("register changed inside a frame");
endmodule
bind sfd_spi_diag sfd_chk u_sfd_chk (.sys_clk, .sys_rst, .spi_clk, .spi_cs_n, .spi_si, .spi_so_out,
	.spi_so_oe_n, .sense_in, .cfg_regs_q);

// ==== sfd_spi_master.sv ====
`timescale 1ns/1ns
module sfd_spi_master (
	// Link clock
	input wire logic link_clk,
	// Serial link
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_si,
	input wire logic spi_so
);
	// ----------------
	// Mode 1 master: drive on rising, sample on falling
	// ----------------
	initial {spi_clk, spi_cs_n, spi_si} = 3'h2;
	// The clock stands still between frames; lead, half period and gap keep the device timing.
	task automatic xfer(input logic [31:0] cmd, input int nbits, output logic [15:0] resp);
		resp = 16'h0000;
		@(posedge link_clk);
		spi_cs_n <= 1'b0;
		repeat (20) @(posedge link_clk);
		for (int i = nbits - 1; i >= 0; i--) begin
			spi_clk <= 1'b1;
			spi_si <= cmd[i];
			repeat (10) @(posedge link_clk);
			spi_clk <= 1'b0;
			if (nbits - i <= 16) resp = {resp[14:0], spi_so};
			repeat (10) @(posedge link_clk);
		end
		if (nbits < 16) resp = resp << (16 - nbits);
		repeat (10) @(posedge link_clk);
		spi_cs_n <= 1'b1;
		spi_si <= ~spi_si;
		repeat (30) @(posedge link_clk);
	endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic link_clk = 1'b0;
	logic spi_clk, spi_cs_n, spi_si, spi_so_out, spi_so_oe_n, so_line;
	logic so_last = 1'b0;
	logic [8:0][7:0] cfg_regs_q;
	sfd_pkg::sfd_sense_type sense_in = 13'h1800;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	// ----------------
	// Clocks, serial line and scenarios
	// ----------------
	always #10 sys_clk = ~sys_clk;
	initial #3 forever #6 link_clk = ~link_clk;
	always @(posedge sys_clk) if (!spi_so_oe_n) so_last <= spi_so_out;
	// A released line shows the inverse of its last level, so a stale bit never passes.
	assign so_line = spi_so_oe_n ? ~so_last : spi_so_out;
	sfd_spi_diag u_sfd_spi_diag (.sys_clk, .sys_rst, .spi_clk, .spi_cs_n, .spi_si, .spi_so_out,
		.spi_so_oe_n, .sense_in, .cfg_regs_q);
	sfd_spi_master u_sfd_spi_master (.link_clk, .spi_clk, .spi_cs_n, .spi_si, .spi_so(so_line));
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic fr(input logic [31:0] c, input int n, input logic [15:0] e);
		logic [15:0] r;
		u_sfd_spi_master.xfer(c, n, r);
		`CHK(r, e)
	endtask
	task automatic sense(input logic [12:0] v);
		@(posedge sys_clk);
		sense_in <= v;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic t_reset();
		fr(32'h0001, 16, 16'h3c00);
		fr(32'h0001, 16, 16'h3800);
		$display("reset test done");
	endtask
	task automatic t_error();
		int bad[4] = '{8, 12, 17, 23};
		foreach (bad[i]) begin
			fr(32'h0001, bad[i], 16'h1800);
			fr(32'h0001, 16, 16'h1c00);
		end
		fr(32'h00ff_0001, 24, 16'h1800);
		fr(32'h0001, 16, 16'h1800);
		$display("error test done");
	endtask
	task automatic t_regs();
		fr(32'h8320, 16, 16'h1800);
		fr(32'h0300, 16, 16'h8300);
		sense(13'h1808);
		fr(32'h0001, 16, 16'h8320);
		fr(32'h8320, 16, 16'h1880);
		fr(32'h0001, 16, 16'h8330);
		fr(32'h0001, 16, 16'h1800);
		sense(13'h1800);
		$display("register test done");
	endtask
	task automatic t_unmap();
		logic [8:0][7:0] e;
		e = sfd_pkg::REG_RESET;
		e[sfd_pkg::IDX_CAL] = 8'h20;
		fr(32'h8155, 16, 16'h1800);
		fr(32'hc3ff, 16, 16'h1800);
		fr(32'h0001, 16, 16'h1800);
		`CHK(cfg_regs_q, e)
		$display("unmapped test done");
	endtask
	task automatic t_latch();
		sense(13'h18f0);
		sense(13'h1800);
		fr(32'h0001, 16, 16'h1800);
		fr(32'h0301, 16, 16'h1836);
		fr(32'h8604, 16, 16'h1802);
		sense(13'h1700);
		fr(32'h0001, 16, 16'h8600);
		fr(32'h0001, 16, 16'h5009);
		sense(13'h0700);
		fr(32'h0001, 16, 16'h5009);
		fr(32'h0001, 16, 16'h5009);
		sense(13'h1800);
		$display("latch test done");
	endtask
	task automatic t_misc();
		sense(13'h1806);
		fr(32'h0001, 16, 16'h5009);
		fr(32'h0001, 16, 16'h1b00);
		fr(32'h8c20, 16, 16'h1b00);
		fr(32'h8920, 16, 16'h8c10);
		fr(32'h0001, 16, 16'h8910);
		fr(32'h8602, 16, 16'h1800);
		`CHK(cfg_regs_q, sfd_pkg::REG_RESET)
		fr(32'h0001, 16, 16'h8600);
		fr(32'h0001, 16, 16'h5800);
		sense(13'h1807);
		fr(32'h0300, 16, 16'h1800);
		fr(32'h0001, 16, 16'h3800);
		sense(13'h1800);
		fr(32'h0001, 16, 16'h1800);
		$display("mirror test done");
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_error();
		t_regs();
		t_unmap();
		t_latch();
		t_misc();
		summarize();
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end
endmodule
